// file: design/drive_runtime_clock_sync.v
// Drive runtime clock: ms-of-day and day counters, operating hours,
// master time following with halt/reset correction, and a diagnostic log.
// Assumes sync words, retained values and events come from logic on ref_clk.
`timescale 1ns/10ps
`include "drive_clock_map.vh"

module drive_runtime_clock_sync
#(
	parameter TICK_CYCLES = `TICK_PERIOD_NS / `REF_CLK_NS   // Cycles per 1 ms tick
)
(
	// Clock and reset
	input  wire                  ref_clk,
	input  wire                  rst_n,
	// Retained values from nonvolatile store
	input  wire                  nv_load,
	input  wire [`MS_W-1:0]      nv_ms,
	input  wire [`DAY_W-1:0]     nv_days,
	input  wire [`MS_W-1:0]      nv_op_ms,
	input  wire [`DAY_W-1:0]     nv_op_days,
	// Master time message
	input  wire                  sync_valid,
	input  wire [`MS_W-1:0]      sync_ms,
	input  wire [`DAY_W-1:0]     sync_days,
	// Threshold configuration
	input  wire                  thr_wr_en,
	input  wire [`THR_W-1:0]     thr_wr_value,
	// Fault and alarm events
	input  wire                  event_in,
	input  wire                  stamp_utc_mode,
	// Log read port
	input  wire [`LOG_AW-1:0]    log_rd_addr,
	output wire [`LOG_DW-1:0]    log_rd_data,
	// Clock state
	output reg  [`MS_W-1:0]      runtime_ms_q,
	output reg  [`DAY_W-1:0]     runtime_days_q,
	output reg  [`MS_W-1:0]      op_ms_q,
	output reg  [`DAY_W-1:0]     op_days_q,
	output reg                   epoch_1992_q,
	output reg                   synced_q,
	output reg                   clock_halted_q,
	output reg  [`THR_W-1:0]     backward_jump_threshold_q,
	// Resync time record
	output reg                   resync_record_valid_q,
	output reg  [`MS_W-1:0]      rec_after_ms_q,
	output reg  [`DAY_W-1:0]     rec_after_days_q,
	output reg  [`MS_W-1:0]      rec_before_ms_q,
	output reg  [`DAY_W-1:0]     rec_before_days_q,
	// Log write position
	output reg  [`LOG_AW-1:0]    log_wptr_q
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Total milliseconds from days and ms of day
	function [`TOT_W-1:0] to_total;
		input [`DAY_W-1:0] d;
		input [`MS_W-1:0]  m;
		begin
			to_total = {{(`TOT_W-`DAY_W){1'b0}}, d} * {{(`TOT_W-`MS_W){1'b0}}, `DAY_MS}
				+ {{(`TOT_W-`MS_W){1'b0}}, m};
		end
	endfunction

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	localparam integer       TICK_LAST_I = TICK_CYCLES - 1;              // Last count, full width
	localparam [`TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`TICK_W-1:0];     // Cut to divider width

	reg  [`TICK_W-1:0] tick_cnt_q;   // Divider count
	reg                tick_q;       // One-cycle 1 ms tick

	// Divide ref_clk down to a 1 ms tick
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_q <= {`TICK_W{1'b0}};
			tick_q     <= 1'b0;
		end
		else if (tick_cnt_q == TICK_LAST)
		begin
			tick_cnt_q <= {`TICK_W{1'b0}};
			tick_q     <= 1'b1;   // R17
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q     <= 1'b0;
		end
	end

	// ****************************************************************
	// Sync decision
	// ****************************************************************
	wire [`TOT_W-1:0] local_tot = to_total(runtime_days_q, runtime_ms_q);  // Own time
	wire [`TOT_W-1:0] recv_tot  = to_total(sync_days, sync_ms);            // Master time
	wire [`TOT_W-1:0] back_diff = local_tot - recv_tot;                    // Deficit
	wire              sync_ok   = sync_valid && (sync_ms < `DAY_MS);       // Sane message
	wire              is_ahead  = recv_tot > local_tot;                    // Forward jump
	wire              is_behind = recv_tot < local_tot;                    // Backward jump
	wire              big_back  = back_diff >
		{{(`TOT_W-`THR_W){1'b0}}, backward_jump_threshold_q};             // Over threshold
	wire              do_load   = sync_ok && (is_ahead || (is_behind && big_back));
	wire              do_halt   = sync_ok && is_behind && !big_back;
	wire              corr_log  = sync_ok && synced_q && is_behind && big_back &&
		(back_diff > `CORR_LOG_MS);                                         // Long reset
	wire              first_log = sync_ok && !synced_q;                    // First sync
	wire [`TOT_W-1:0] corr_s    = back_diff / `MS_PER_S;                   // Seconds

	// ****************************************************************
	// Threshold
	// ****************************************************************

	// Configurable backward jump threshold
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			backward_jump_threshold_q <= `THR_RESET_MS;   // R15
		end
		else if (thr_wr_en)
		begin
			backward_jump_threshold_q <= thr_wr_value;
		end
	end

	// ****************************************************************
	// Runtime clock
	// ****************************************************************
	reg [`THR_W-1:0] halt_left_q;   // Ticks still to hold

	// Runtime ms and day counters with load, halt and wrap
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			runtime_ms_q   <= {`MS_W{1'b0}};
			runtime_days_q <= {`DAY_W{1'b0}};
			clock_halted_q <= 1'b0;
			halt_left_q    <= {`THR_W{1'b0}};
		end
		else if (nv_load)
		begin
			// Resume from retained values
			runtime_ms_q   <= nv_ms;     // R04
			runtime_days_q <= nv_days;   // R04
			clock_halted_q <= 1'b0;
			halt_left_q    <= {`THR_W{1'b0}};
		end
		else if (do_load)
		begin
			// Forward jump or large backward jump: take master time
			runtime_ms_q   <= sync_ms;     // R12 R14
			runtime_days_q <= sync_days;   // R09
			clock_halted_q <= 1'b0;
			halt_left_q    <= {`THR_W{1'b0}};
		end
		else if (do_halt)
		begin
			// Small backward jump: hold until master catches up
			clock_halted_q <= 1'b1;                    // R13
			halt_left_q    <= back_diff[`THR_W-1:0];   // R13
		end
		else if (tick_q && clock_halted_q)
		begin
			// Frozen: count down the deficit instead of the time
			halt_left_q <= halt_left_q - 1'b1;   // R13
			if (halt_left_q == {{(`THR_W-1){1'b0}}, 1'b1})
			begin
				clock_halted_q <= 1'b0;
			end
		end
		else if (tick_q)
		begin
			if (runtime_ms_q == `DAY_MS - 1'b1)
			begin
				// End of day: wrap and count a day
				runtime_ms_q   <= {`MS_W{1'b0}};            // R01
				runtime_days_q <= runtime_days_q + 1'b1;   // R02 R03
			end
			else
			begin
				runtime_ms_q <= runtime_ms_q + 1'b1;   // R03
			end
		end
	end

	// ****************************************************************
	// Operating hours counter
	// ****************************************************************

	// Operating hours always run, unaffected by sync
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_ms_q   <= {`MS_W{1'b0}};
			op_days_q <= {`DAY_W{1'b0}};
		end
		else if (nv_load)
		begin
			op_ms_q   <= nv_op_ms;     // R04
			op_days_q <= nv_op_days;   // R04
		end
		else if (tick_q)
		begin
			if (op_ms_q == `DAY_MS - 1'b1)
			begin
				op_ms_q   <= {`MS_W{1'b0}};
				op_days_q <= op_days_q + 1'b1;
			end
			else
			begin
				op_ms_q <= op_ms_q + 1'b1;
			end
		end
	end

	// ****************************************************************
	// Sync state and resync record
	// ****************************************************************

	// Synced flag, epoch marker and before/after record
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			synced_q              <= 1'b0;
			epoch_1992_q          <= 1'b1;
			resync_record_valid_q <= 1'b0;
			rec_after_ms_q        <= {`MS_W{1'b0}};
			rec_after_days_q      <= {`DAY_W{1'b0}};
			rec_before_ms_q       <= {`MS_W{1'b0}};
			rec_before_days_q     <= {`DAY_W{1'b0}};
		end
		else
		begin
			if (sync_ok)
			begin
				synced_q     <= 1'b1;   // R10
				epoch_1992_q <= 1'b0;   // R05
			end
			if (sync_ok && is_behind && big_back)
			begin
				// Large backward resync: keep after and before times
				resync_record_valid_q <= 1'b1;             // R19
				rec_after_ms_q        <= sync_ms;          // R19
				rec_after_days_q      <= sync_days;        // R19
				rec_before_ms_q       <= runtime_ms_q;     // R19
				rec_before_days_q     <= runtime_days_q;   // R19
			end
		end
	end

	// ****************************************************************
	// Diagnostic log writer
	// ****************************************************************
	reg                log_we_q;      // Write strobe to memory
	reg [`LOG_DW-1:0]  log_wdata_q;   // Entry to write
	reg                evt_pend_q;    // Event waiting for a free slot

	// Event stamp: operating hours unless UTC stamping is chosen and synced
	wire               stamp_utc = stamp_utc_mode && synced_q;   // R06 R10
	wire [`KIND_W-1:0] evt_kind  = stamp_utc ? `KIND_EVT_UTC : `KIND_EVT_OPH;
	wire [`MS_W-1:0]   evt_ms    = stamp_utc ? runtime_ms_q : op_ms_q;
	wire [`DAY_W-1:0]  evt_days  = stamp_utc ? runtime_days_q : op_days_q;
	wire               evt_go    = event_in || evt_pend_q;   // Event to log
	wire               sync_go   = first_log || corr_log;    // Sync entry to log

	// Append entries; sync entries first, an event waits one slot
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			log_we_q    <= 1'b0;
			log_wdata_q <= {`LOG_DW{1'b0}};
			log_wptr_q  <= {`LOG_AW{1'b0}};
			evt_pend_q  <= 1'b0;
		end
		else
		begin
			// Advance past the entry written last cycle, wrapping from 15 back to 0
			if (log_we_q)
			begin
				log_wptr_q <= log_wptr_q + 1'b1;   // R20
			end
			if (first_log)
			begin
				// First sync: operating hours and new UTC time
				log_we_q    <= 1'b1;   // R11
				log_wdata_q <= {`KIND_FIRST_SYNC, op_ms_q, op_days_q,
					sync_ms, sync_days};   // R11
				evt_pend_q  <= evt_go;
			end
			else if (corr_log)
			begin
				// Long backward reset: correction in whole seconds
				log_we_q    <= 1'b1;   // R18
				log_wdata_q <= {`KIND_CORRECTION, runtime_ms_q, runtime_days_q,
					corr_s[`MS_W-1:0], {`DAY_W{1'b0}}};   // R18
				evt_pend_q  <= evt_go;
			end
			else if (evt_go)
			begin
				// Fault or alarm with its stamp
				log_we_q    <= 1'b1;   // R06
				log_wdata_q <= {evt_kind, evt_ms, evt_days,
					{`MS_W{1'b0}}, {`DAY_W{1'b0}}};   // R10
				evt_pend_q  <= 1'b0;
			end
			else
			begin
				log_we_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Log storage
	// ****************************************************************

	// Entries are appended in a ring of 16; stored stamps stay as written until the ring wraps
	diag_log_mem u_log
	(
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.wr_en     (log_we_q),
		.wr_addr   (log_wptr_q),
		.wr_data   (log_wdata_q),
		.rd_addr   (log_rd_addr),
		.rd_data_q (log_rd_data)
	);

endmodule

// file: design/drive_clock_map.vh
// Constants of the drive runtime clock: widths, day length, timing, log kinds.
// Assumes one 125 MHz clock; included by the clock top and its log memory.
//
// Behaviour
// R01: Millisecond count wraps at one full day
// R02: Day count kept beside millisecond count
// R03: Tick advances ms; wrap increments days
// R04: Counts restored from retained values at power-up
// R05: Unsynced time counts from 1992 midnight epoch
// R06: Events stamped with operating hours by default
// R07: Master sends time only by sync message
// R08: Master first sends after reaching running state
// R09: Periodic resend; device resyncs each time
// R10: Pre-sync events keep local stamp, later synced
// R11: First sync logs operating hours and UTC
// R12: Later received time loads at once
// R13: Small backward jump freezes clock until caught up
// R14: Large backward jump resets clock to received
// R15: Backward jump threshold defaults to 100 ms
// R16: Master pushes time after own deliberate reset
// R17: Clock resolution is one millisecond
// R18: Backward reset over 60 s logs seconds
// R19: Large resync exposes after and before times
// R20: Logged entries never rewritten on clock change
// R21: Master shows whether automatic sync active
`ifndef DRIVE_CLOCK_MAP_VH
`define DRIVE_CLOCK_MAP_VH

// ****************************************************************
// Widths
// ****************************************************************
`define MS_W            27
`define DAY_W           16
`define TOT_W           48
`define THR_W           32
`define TICK_W          20
`define LOG_AW          4
`define LOG_DW          90
`define KIND_W          4

// ****************************************************************
// Time values
// ****************************************************************
`define DAY_MS          27'h5265c00
`define THR_RESET_MS    32'h00000064
`define CORR_LOG_MS     48'h00000000ea60
`define MS_PER_S        48'h0000000003e8
`define TICK_PERIOD_NS  1000000
`define REF_CLK_NS      8
`define EPOCH_YEAR      1992

// ****************************************************************
// Log entry kinds
// ****************************************************************
`define KIND_EVT_OPH    4'h1
`define KIND_EVT_UTC    4'h2
`define KIND_FIRST_SYNC 4'h3
`define KIND_CORRECTION 4'h4

`endif

// file: design/diag_log_mem.v
// Small memory holding diagnostic log entries, one write and one read port.
// Assumes the writer appends only; its pointer wraps, so an entry is rewritten after 16 more.
`timescale 1ns/10ps
`include "drive_clock_map.vh"

module diag_log_mem
(
	// Clock and reset
	input  wire                  clk,
	input  wire                  rst_n,
	// Write port
	input  wire                  wr_en,
	input  wire [`LOG_AW-1:0]    wr_addr,
	input  wire [`LOG_DW-1:0]    wr_data,
	// Read port
	input  wire [`LOG_AW-1:0]    rd_addr,
	output reg  [`LOG_DW-1:0]    rd_data_q
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	reg [`LOG_DW-1:0] mem [0:(1<<`LOG_AW)-1];   // Entry array, no reset

	// Write side: one entry per write strobe
	always @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read side: registered read data
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data_q <= {`LOG_DW{1'b0}};
		end
		else
		begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule

// file: test/drive_clock_checker.sv
// Port assertions for the drive runtime clock.
// Assumes the clock map header is on the include path.
`timescale 1ns/10ps
`include "drive_clock_map.vh"

module drive_clock_checker
(
	// Clock, reset and inputs
	input wire                 ref_clk,
	input wire                 rst_n,
	input wire                 nv_load,
	input wire                 sync_valid,
	input wire [`MS_W-1:0]     sync_ms,
	input wire [`DAY_W-1:0]    sync_days,
	input wire                 thr_wr_en,
	input wire [`THR_W-1:0]    thr_wr_value,
	// Observed state
	input wire [`MS_W-1:0]     runtime_ms_q,
	input wire [`DAY_W-1:0]    runtime_days_q,
	input wire                 epoch_1992_q,
	input wire                 synced_q,
	input wire                 clock_halted_q,
	input wire [`THR_W-1:0]    backward_jump_threshold_q,
	input wire                 resync_record_valid_q,
	input wire [`MS_W-1:0]     rec_after_ms_q,
	input wire [`MS_W-1:0]     rec_before_ms_q,
	input wire [`LOG_AW-1:0]   log_wptr_q
);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Local and received time as total milliseconds
	wire [`TOT_W-1:0] loc_t = {32'h0, runtime_days_q} * {21'h0, `DAY_MS} + {21'h0, runtime_ms_q};
	wire [`TOT_W-1:0] rcv_t = {32'h0, sync_days} * {21'h0, `DAY_MS} + {21'h0, sync_ms};
	wire [`TOT_W-1:0] gap   = loc_t - rcv_t;
	wire              ok_s  = sync_valid && (sync_ms < `DAY_MS) && !nv_load;
	wire              back  = ok_s && (loc_t > rcv_t);
	wire              big   = back && (gap > {16'h0, backward_jump_threshold_q});

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_ms_in_day: assert property (runtime_ms_q < `DAY_MS)
		else $error("ms of day out of range");
	a_day_step: assert property ($changed(runtime_days_q) && !$past(nv_load)
		&& !$past(sync_valid)
		|-> runtime_ms_q == 27'h0 && runtime_days_q - $past(runtime_days_q) == 16'h1)
		else $error("day count moved without ms wrap");
	a_halt_freeze: assert property ($past(clock_halted_q) && !$past(sync_valid)
		&& !$past(nv_load)
		|-> $stable(runtime_ms_q) && $stable(runtime_days_q))
		else $error("clock moved while halted");
	a_sync_state: assert property (ok_s |=> synced_q && !epoch_1992_q)
		else $error("sync did not mark synced");
	a_fwd_load: assert property (ok_s && rcv_t > loc_t
		|=> runtime_ms_q == $past(sync_ms) && runtime_days_q == $past(sync_days))
		else $error("later time not loaded");
	a_small_halt: assert property (back && !big |=> clock_halted_q && $stable(runtime_ms_q))
		else $error("small backward jump did not halt");
	a_big_reset: assert property (big |=> runtime_ms_q == $past(sync_ms)
		&& resync_record_valid_q
		&& rec_after_ms_q == $past(sync_ms) && rec_before_ms_q == $past(runtime_ms_q))
		else $error("large backward jump not reset or recorded");
	a_thr_write: assert property (thr_wr_en |=> backward_jump_threshold_q == $past(thr_wr_value))
		else $error("threshold write lost");
	a_log_append: assert property ($changed(log_wptr_q) |-> log_wptr_q - $past(log_wptr_q) == 4'h1)
		else $error("log pointer jumped");
	a_first_log: assert property ($rose(synced_q) |=> log_wptr_q != $past(log_wptr_q))
		else $error("first sync not logged");

	// Main scenarios reached
	c_big: cover property (big);
	c_small: cover property (back && !big);
	c_halt_end: cover property (clock_halted_q ##1 !clock_halted_q);
endmodule

// file: test/master_time_src.sv
// Master side model: sends time messages to the drive on request.
// Assumes the bench raises req for one cycle per message.
`timescale 1ns/10ps
`include "drive_clock_map.vh"

module master_time_src
(
	// Clock and reset
	input  wire               ref_clk,
	input  wire               rst_n,
	// Bench requests
	input  wire               run_state,
	input  wire               req,
	input  wire [`MS_W-1:0]   req_ms,
	input  wire [`DAY_W-1:0]  req_days,
	// Time message towards the drive
	output reg                sync_valid,
	output reg  [`MS_W-1:0]   sync_ms,
	output reg  [`DAY_W-1:0]  sync_days,
	output reg                clocks_synced_flag
);
	// One message per request, only once running
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_valid <= 1'b0;
			sync_ms <= 27'h0;
			sync_days <= 16'h0;
			clocks_synced_flag <= 1'b0;
		end
		else if (req && run_state)
		begin
			sync_valid <= 1'b1;
			sync_ms <= req_ms;
			sync_days <= req_days;
			clocks_synced_flag <= 1'b1;
		end
		else
		begin
			// Idle lines toggle each cycle between the last time and its inverse
			sync_valid <= 1'b0;
			sync_ms <= ~sync_ms;
			sync_days <= ~sync_days;
		end
	end
endmodule

// file: test/testbench.sv
// Self-checking bench for the drive runtime clock with a master model.
// Assumes design/ and test/ on the include path; tick shortened to 10 cycles.
`timescale 1ns/10ps
`include "drive_clock_map.vh"

module testbench;
	// Design inputs
	reg                 ref_clk, rst_n, nv_load, thr_wr_en, event_in, stamp_utc_mode, m_req;
	reg  [`MS_W-1:0]    nv_ms, nv_op_ms, m_ms, f;
	reg  [`DAY_W-1:0]   nv_days, nv_op_days;
	reg  [`THR_W-1:0]   thr_wr_value;
	reg  [`LOG_AW-1:0]  log_rd_addr;
	reg  [`LOG_DW-1:0]  ent;
	// Design outputs
	wire [`LOG_DW-1:0]  log_rd_data;
	wire [`MS_W-1:0]    runtime_ms_q, op_ms_q, rec_after_ms_q, rec_before_ms_q, sync_ms;
	wire [`DAY_W-1:0]   runtime_days_q, op_days_q, rec_after_days_q, rec_before_days_q, sync_days;
	wire                epoch_1992_q, synced_q, clock_halted_q, resync_record_valid_q, sync_valid;
	wire [`THR_W-1:0]   backward_jump_threshold_q;
	wire [`LOG_AW-1:0]  log_wptr_q;
	integer             err_total, n_tests, i;

	drive_runtime_clock_sync #(.TICK_CYCLES(10)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.nv_load(nv_load), .nv_ms(nv_ms), .nv_days(nv_days), .nv_op_ms(nv_op_ms),
		.nv_op_days(nv_op_days), .sync_valid(sync_valid), .sync_ms(sync_ms),
		.sync_days(sync_days), .thr_wr_en(thr_wr_en), .thr_wr_value(thr_wr_value),
		.event_in(event_in), .stamp_utc_mode(stamp_utc_mode), .log_rd_addr(log_rd_addr),
		.log_rd_data(log_rd_data), .runtime_ms_q(runtime_ms_q), .runtime_days_q(runtime_days_q),
		.op_ms_q(op_ms_q), .op_days_q(op_days_q), .epoch_1992_q(epoch_1992_q),
		.synced_q(synced_q), .clock_halted_q(clock_halted_q),
		.backward_jump_threshold_q(backward_jump_threshold_q),
		.resync_record_valid_q(resync_record_valid_q), .rec_after_ms_q(rec_after_ms_q),
		.rec_after_days_q(rec_after_days_q), .rec_before_ms_q(rec_before_ms_q),
		.rec_before_days_q(rec_before_days_q), .log_wptr_q(log_wptr_q));

	master_time_src u_master (.ref_clk(ref_clk), .rst_n(rst_n), .run_state(1'b1), .req(m_req),
		.req_ms(m_ms), .req_days(16'h0009), .sync_valid(sync_valid), .sync_ms(sync_ms),
		.sync_days(sync_days), .clocks_synced_flag());

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	task chk(input [47:0] got, input [47:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp)
			begin
				err_total = err_total + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task tmo;
		begin
			err_total = err_total + 1;
			$display("wrong value at %0t: wait timed out", $time);
			stop_test;
		end
	endtask

	// Master message; design has taken it on return
	task send(input [`MS_W-1:0] ms);
		begin
			@(posedge ref_clk);
			m_req <= 1'b1;
			m_ms <= ms;
			@(posedge ref_clk);
			m_req <= 1'b0;
			@(posedge ref_clk);
			#1;
		end
	endtask

	// Read the newest entry once its write has moved the pointer on
	task rd_log;
		begin
			repeat (2) @(posedge ref_clk);
			log_rd_addr <= log_wptr_q - 4'h1;
			repeat (2) @(posedge ref_clk);
			#1;
			ent = log_rd_data;
		end
	endtask

	// Threshold write, read back after the edge that takes it
	task wr_thr(input [`THR_W-1:0] v);
		begin
			@(posedge ref_clk);
			thr_wr_en <= 1'b1;
			thr_wr_value <= v;
			@(posedge ref_clk);
			thr_wr_en <= 1'b0;
			#1;
			chk(backward_jump_threshold_q, v);
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_nv;
		begin
			chk(epoch_1992_q, 1'b1);
			chk(backward_jump_threshold_q, 32'h64);
			@(posedge ref_clk);
			nv_load <= 1'b1;
			@(posedge ref_clk);
			nv_load <= 1'b0;
			#1;
			chk(runtime_ms_q, `DAY_MS - 27'h2);
			chk(op_days_q, 16'h3);
			chk(op_ms_q, 27'h7);
			for (i = 0; i < 40 && runtime_days_q === 16'h5; i = i + 1)
				@(posedge ref_clk) #1;
			if (i == 40)
				tmo;
			chk({runtime_days_q, runtime_ms_q}, {16'h6, 27'h0});
			$display("test nv done");
		end
	endtask

	task t_evt(input md, input [3:0] kind);
		begin
			@(posedge ref_clk);
			stamp_utc_mode <= md;
			event_in <= 1'b1;
			@(posedge ref_clk);
			event_in <= 1'b0;
			repeat (2) @(posedge ref_clk);
			rd_log;
			chk(ent[89:86], kind);
			$display("test event done");
		end
	endtask

	task t_fwd;
		begin
			send(27'hf4240);
			chk({runtime_days_q, runtime_ms_q}, {16'h9, 27'hf4240});
			chk({synced_q, epoch_1992_q}, 2'b10);
			rd_log;
			chk({ent[89:86], ent[42:0]}, {4'h3, 27'hf4240, 16'h9});
			$display("test forward done");
		end
	endtask

	task t_halt;
		begin
			send(runtime_ms_q - 27'h32);
			chk(clock_halted_q, 1'b1);
			f = runtime_ms_q;
			for (i = 0; i < 900 && clock_halted_q === 1'b1; i = i + 1)
				@(posedge ref_clk) #1;
			if (i == 900)
				tmo;
			chk(runtime_ms_q, f);
			$display("test halt done");
		end
	endtask

	task t_thr;
		begin
			wr_thr(32'hc8);
			send(runtime_ms_q - 27'h96);
			chk(clock_halted_q, 1'b1);
			wr_thr(32'h64);
			f = runtime_ms_q;
			send(f - 27'h64);
			chk({clock_halted_q, runtime_ms_q}, {1'b1, f});
			send(f - 27'h65);
			chk({clock_halted_q, runtime_ms_q}, {1'b0, f - 27'h65});
			chk({rec_before_ms_q, rec_after_ms_q}, {f, f - 27'h65});
			chk(resync_record_valid_q, 1'b1);
			chk({rec_before_days_q, rec_after_days_q}, {16'h9, 16'h9});
			i = log_wptr_q;
			repeat (3) @(posedge ref_clk);
			chk(log_wptr_q, i[3:0]);
			$display("test threshold done");
		end
	endtask

	task t_corr;
		begin
			send(runtime_ms_q - 27'h1e);
			f = runtime_ms_q;
			send(f - 27'hf03c);
			chk({runtime_ms_q, rec_before_ms_q}, {f - 27'hf03c, f});
			rd_log;
			chk({ent[89:86], ent[85:59], ent[42:16]}, {4'h4, f, 27'h3d});
			$display("test correction done");
		end
	endtask

	// ****************************************************************
	// Clock and main sequence
	// ****************************************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial
	begin
		err_total = 0;
		n_tests = 0;
		{rst_n, nv_load, thr_wr_en, event_in, stamp_utc_mode, m_req} = 6'h0;
		{nv_ms, nv_days, nv_op_ms, nv_op_days} = {`DAY_MS - 27'h2, 16'h5, 27'h7, 16'h3};
		{m_ms, thr_wr_value, log_rd_addr} = {27'h0, 32'h64, 4'h0};
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		t_nv;
		t_evt(1'b1, 4'h1);
		t_fwd;
		t_evt(1'b1, 4'h2);
		t_evt(1'b0, 4'h1);
		t_halt;
		t_thr;
		t_corr;
		stop_test;
	end
endmodule

bind drive_runtime_clock_sync drive_clock_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.nv_load(nv_load), .sync_valid(sync_valid), .sync_ms(sync_ms), .sync_days(sync_days),
	.thr_wr_en(thr_wr_en), .thr_wr_value(thr_wr_value), .runtime_ms_q(runtime_ms_q),
	.runtime_days_q(runtime_days_q), .epoch_1992_q(epoch_1992_q), .synced_q(synced_q),
	.clock_halted_q(clock_halted_q), .backward_jump_threshold_q(backward_jump_threshold_q),
	.resync_record_valid_q(resync_record_valid_q), .rec_after_ms_q(rec_after_ms_q),
	.rec_before_ms_q(rec_before_ms_q), .log_wptr_q(log_wptr_q));
